// [sii_pkg.sv]
// sii_pkg: constants and carrier types for the signaling / idle-code insertion block
// assumes: 8-bit parallel register port, 32 channel slots per frame, 8 bits per slot

package sii_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SIG_INSERT_ENABLE_1 = 8'h08;
  localparam logic [7:0] ADDR_SIG_INSERT_ENABLE_2 = 8'h09;
  localparam logic [7:0] ADDR_SIG_INSERT_ENABLE_3 = 8'h0a;
  localparam logic [7:0] ADDR_SIG_INSERT_ENABLE_4 = 8'h0b;
  localparam logic [7:0] ADDR_TX_SIG_REG_FIRST    = 8'h50;
  localparam logic [7:0] ADDR_TX_SIG_REG_LAST     = 8'h5f;
  localparam logic [7:0] ADDR_IDLE_ARRAY_ADDRESS  = 8'h7e;
  localparam logic [7:0] ADDR_IDLE_CODE_DATA      = 8'h7f;
  localparam logic [7:0] ADDR_TX_IDLE_ENABLE_1    = 8'h80;
  localparam logic [7:0] ADDR_RX_IDLE_ENABLE_1    = 8'h84;
  localparam logic [7:0] ADDR_HW_SIG_SELECT_1     = 8'h88;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int         BIT_GLOBAL_TX   = 6;
  localparam int         BIT_GLOBAL_RX   = 7;
  localparam int         BIT_ALIGN_SEL   = 0;
  localparam logic [7:0] RESET_REG       = 8'h00;
  localparam int         NUM_CHANNELS    = 32;
  localparam int         T1_CHANNELS     = 24;
  localparam int         CAS_SLOT        = 16;
  localparam int         ARRAY_DEPTH     = 64;
  localparam logic [5:0] RX_BASE         = 6'h20;
  localparam int         BUF_DEPTH       = 2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sii_host_type;

  typedef struct packed {
    logic       is_rx;
    logic [4:0] chan;
    logic [7:0] data;
  } sii_word_type;

endpackage

// [sii_idle_ram.sv]
// sii_idle_ram: 64 x 8 idle code array, one host write port with block fill, two reads
// assumes: host and datapath reads share one clock; read data is registered

`timescale 1ns/100ps

module sii_idle_ram (
  input  wire logic       sys_clk,    // system clock
  input  wire logic       we,         // write strobe
  input  wire logic [5:0] waddr,      // entry to write
  input  wire logic       fill_tx,    // also write all transmit entries
  input  wire logic       fill_rx,    // also write all receive entries
  input  wire logic [7:0] wdata,      // code written
  input  wire logic [5:0] raddr_a,    // host read address
  output logic      [7:0] rdata_a_q,  // host read data
  input  wire logic [5:0] raddr_b,    // datapath read address
  output logic      [7:0] rdata_b_q   // datapath read data
);

  logic [7:0] mem [sii_pkg::ARRAY_DEPTH];

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < sii_pkg::ARRAY_DEPTH; i++) begin
      if (we && ((i[5:0] == waddr) || (fill_tx && !i[5]) || (fill_rx && i[5]))) begin
        mem[i] <= wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    rdata_a_q <= mem[raddr_a];
    rdata_b_q <= mem[raddr_b];
  end

endmodule

// [sii_buf2.sv]
// sii_buf2: two-entry buffer with valid/ready on both sides
// assumes: single clock, asynchronous active-low reset

`timescale 1ns/100ps

module sii_buf2 (
  input  wire logic                  sys_clk,  // system clock
  input  wire logic                  nrst,     // async reset, active low
  input  wire logic                  in_valid, // word offered
  output logic                       in_ready, // room for a word
  input  wire sii_pkg::sii_word_type in_word,  // word in
  output logic                       out_valid,// word available
  input  wire logic                  out_ready,// receiver takes word
  output sii_pkg::sii_word_type      out_word  // word out
);

  sii_pkg::sii_word_type slot_q [sii_pkg::BUF_DEPTH];
  logic [1:0]            count_q;
  logic                  push;
  logic                  pop;

  assign in_ready  = (count_q != 2'(sii_pkg::BUF_DEPTH));
  assign out_valid = (count_q != 2'h0);
  assign out_word  = slot_q[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= 2'h0;
    end else begin
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // slot 0 is the head; a pop shifts slot 1 down
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      slot_q[0] <= '0;
      slot_q[1] <= '0;
    end else begin
      if (pop) begin
        slot_q[0] <= (count_q == 2'h2) ? slot_q[1] : in_word;
        if (push && count_q == 2'h2) begin
          slot_q[1] <= in_word;
        end else if (push) begin
          slot_q[0] <= in_word;
        end
      end else if (push) begin
        if (count_q == 2'h0) begin
          slot_q[0] <= in_word;
        end else begin
          slot_q[1] <= in_word;
        end
      end
    end
  end

endmodule

// [sii_insert.sv]
// sii_insert: per-channel signaling insertion and idle code substitution
// assumes: the framer presents one channel byte per strobe with its slot number and
// direction; host register accesses are single-cycle strobes on the parallel port
//
// Behaviour
// - e1 cas: timeslot 16 align byte from registers
// - upper align nibble selected by enable 1 bit 0
// - lower align nibble selected by enable 3 bit 0
// - e1 per-channel enable bit mapping
// - t1 uses three enable registers, 24 channels
// - hardware mode inserts serial signaling input
// - host selects channels for hardware signaling
// - works with elastic store on or bypassed
// - idle substitution both directions, t1 24 channels
// - 64 byte idle array via address/data
// - substitute only when channel enable set
// - global bits fill all tx/rx entries
// - 0..31 transmit, 32..63 receive
// - code bit 7 sent first, bit 0 last
// - data write advances array pointer

`timescale 1ns/100ps

module sii_insert (
  input  wire logic                  sys_clk,          // 10 MHz system clock
  input  wire logic                  nrst,             // async reset, active low
  input  wire sii_pkg::sii_host_type host,             // register port request
  output logic                [7:0]  host_rdata_q,     // register read data
  input  wire logic                  e1_mode,          // 1 = e1, 0 = t1
  input  wire logic                  cas_mode,         // e1 cas signaling format
  input  wire logic                  hw_sig_mode,      // signaling from serial input
  input  wire logic                  in_valid,         // channel byte offered
  output logic                       in_ready,         // stall for the framer
  input  wire sii_pkg::sii_word_type in_word,          // channel byte, slot, direction
  input  wire logic           [7:0]  tx_signaling_in,  // signaling byte for this slot
  output logic                       out_valid,        // processed byte available
  input  wire logic                  out_ready,        // receiver takes byte
  output sii_pkg::sii_word_type      out_word          // processed byte
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  sig_insert_enable_q [4];
  logic [7:0]  tx_sig_regs_q [16];
  logic [7:0]  idle_array_address_q;
  logic [31:0] tx_idle_enable_regs_q;
  logic [31:0] rx_idle_enable_regs_q;
  logic [31:0] hw_sig_channel_select_q;
  logic [5:0]  idle_array_pointer;
  logic        global_tx_idle_write;
  logic        global_rx_idle_write;
  logic        data_wr;
  logic        data_rd;
  logic [7:0]  ram_host_rdata;
  logic [7:0]  ram_path_rdata;
  logic [5:0]  path_raddr;

  assign idle_array_pointer   = idle_array_address_q[5:0];
  assign global_tx_idle_write = idle_array_address_q[sii_pkg::BIT_GLOBAL_TX];
  assign global_rx_idle_write = idle_array_address_q[sii_pkg::BIT_GLOBAL_RX];
  assign data_wr = host.wr && (host.addr == sii_pkg::ADDR_IDLE_CODE_DATA);
  assign data_rd = host.rd && (host.addr == sii_pkg::ADDR_IDLE_CODE_DATA);

  // offset of an address inside a four-register group, or 3'h4 when outside
  function automatic logic [2:0] group_idx(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    group_idx = (d < 8'h04) ? d[2:0] : 3'h4;
  endfunction

  // ---------------------------------------------------------------
  // host writes
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        sig_insert_enable_q[i] <= sii_pkg::RESET_REG;
      end
      tx_idle_enable_regs_q   <= '0;
      rx_idle_enable_regs_q   <= '0;
      hw_sig_channel_select_q <= '0;
    end else if (host.wr) begin
      for (int i = 0; i < 4; i++) begin
        if (group_idx(host.addr, sii_pkg::ADDR_SIG_INSERT_ENABLE_1) == 3'(i)) begin
          sig_insert_enable_q[i] <= host.wdata;
        end
        if (group_idx(host.addr, sii_pkg::ADDR_TX_IDLE_ENABLE_1) == 3'(i)) begin
          tx_idle_enable_regs_q[i*8 +: 8] <= host.wdata;
        end
        if (group_idx(host.addr, sii_pkg::ADDR_RX_IDLE_ENABLE_1) == 3'(i)) begin
          rx_idle_enable_regs_q[i*8 +: 8] <= host.wdata;
        end
        if (group_idx(host.addr, sii_pkg::ADDR_HW_SIG_SELECT_1) == 3'(i)) begin
          hw_sig_channel_select_q[i*8 +: 8] <= host.wdata;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) begin
        tx_sig_regs_q[i] <= sii_pkg::RESET_REG;
      end
    end else if (host.wr && host.addr >= sii_pkg::ADDR_TX_SIG_REG_FIRST
                 && host.addr <= sii_pkg::ADDR_TX_SIG_REG_LAST) begin
      tx_sig_regs_q[host.addr[3:0]] <= host.wdata;
    end
  end

  // address written first, then each data write steps the pointer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      idle_array_address_q <= sii_pkg::RESET_REG;
    end else if (host.wr && host.addr == sii_pkg::ADDR_IDLE_ARRAY_ADDRESS) begin
      idle_array_address_q <= host.wdata;
    end else if (data_wr) begin
      idle_array_address_q[5:0] <= idle_array_pointer + 6'h01;
    end
  end

  // the host must keep the pointer inside a filled block a stale
  // global bit during a read is harmless here since reads never write
  sii_idle_ram u_ram (
    .sys_clk   (sys_clk),
    .we        (data_wr),
    .waddr     (idle_array_pointer),
    .fill_tx   (global_tx_idle_write),
    .fill_rx   (global_rx_idle_write),
    .wdata     (host.wdata),
    .raddr_a   (idle_array_pointer),
    .rdata_a_q (ram_host_rdata),
    .raddr_b   (path_raddr),
    .rdata_b_q (ram_path_rdata)
  );

  // ---------------------------------------------------------------
  // host reads: registered one cycle after the strobe
  // ---------------------------------------------------------------
  logic       rd_data_q;
  logic [7:0] rd_other_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q  <= 1'b0;
      rd_other_q <= 8'h00;
    end else begin
      rd_data_q  <= data_rd;
      rd_other_q <= 8'h00;
      if (host.rd) begin
        for (int i = 0; i < 4; i++) begin
          if (group_idx(host.addr, sii_pkg::ADDR_SIG_INSERT_ENABLE_1) == 3'(i)) begin
            rd_other_q <= sig_insert_enable_q[i];
          end
          if (group_idx(host.addr, sii_pkg::ADDR_TX_IDLE_ENABLE_1) == 3'(i)) begin
            rd_other_q <= tx_idle_enable_regs_q[i*8 +: 8];
          end
          if (group_idx(host.addr, sii_pkg::ADDR_RX_IDLE_ENABLE_1) == 3'(i)) begin
            rd_other_q <= rx_idle_enable_regs_q[i*8 +: 8];
          end
          if (group_idx(host.addr, sii_pkg::ADDR_HW_SIG_SELECT_1) == 3'(i)) begin
            rd_other_q <= hw_sig_channel_select_q[i*8 +: 8];
          end
        end
        if (host.addr >= sii_pkg::ADDR_TX_SIG_REG_FIRST
            && host.addr <= sii_pkg::ADDR_TX_SIG_REG_LAST) begin
          rd_other_q <= tx_sig_regs_q[host.addr[3:0]];
        end
        if (host.addr == sii_pkg::ADDR_IDLE_ARRAY_ADDRESS) begin
          rd_other_q <= idle_array_address_q;
        end
      end
    end
  end

  assign host_rdata_q = rd_data_q ? ram_host_rdata : rd_other_q;

  // ---------------------------------------------------------------
  // software signaling enable per slot
  // ---------------------------------------------------------------
  function automatic logic sw_sig_enable(input logic [4:0] ch, input logic e1);
    logic [4:0] ch1;
    sw_sig_enable = 1'b0;
    if (!e1) begin
      // t1: bits 0..7 of enables 1..3 cover channels 1..24
      sw_sig_enable = (ch < 5'(sii_pkg::T1_CHANNELS)) ?
                      sig_insert_enable_q[ch[4:3]][ch[2:0]] : 1'b0;
    end else if (ch != 5'h00 && ch != 5'(sii_pkg::CAS_SLOT)) begin
      // e1 phone channel numbering skips slot 16
      ch1 = (ch < 5'(sii_pkg::CAS_SLOT)) ? ch : ch - 5'h01;
      case (1'b1)
        (ch1 <= 5'd7):  sw_sig_enable = sig_insert_enable_q[0][ch1[2:0]];
        (ch1 <= 5'd15): sw_sig_enable = sig_insert_enable_q[1][3'(ch1 - 5'd8)];
        (ch1 <= 5'd22): sw_sig_enable = sig_insert_enable_q[2][3'(ch1 - 5'd15)];
        default:        sw_sig_enable = sig_insert_enable_q[3][3'(ch1 - 5'd23)];
      endcase
    end
  endfunction

  // software signaling nibble for a slot, from the pair-packed registers
  function automatic logic [3:0] sw_sig_nibble(input logic [4:0] ch, input logic e1);
    logic [4:0] ph;
    logic [7:0] r;
    // odd numbers sit in the low nibble; e1 phone channels start one register later
    ph = e1 ? ((ch < 5'(sii_pkg::CAS_SLOT)) ? ch : ch - 5'h01) : ch + 5'h01;
    r  = tx_sig_regs_q[4'(e1 ? (ph + 5'h01) >> 1 : (ph - 5'h01) >> 1)];
    sw_sig_nibble = ph[0] ? r[3:0] : r[7:4];
  endfunction

  // ---------------------------------------------------------------
  // datapath: one cycle for the array read, then the buffer
  // ---------------------------------------------------------------
  logic                  stage_valid_q;
  sii_pkg::sii_word_type stage_q;
  logic [7:0]            stage_sig_q;
  logic                  buf_in_ready;
  sii_pkg::sii_word_type result;
  logic                  idle_on;
  logic [7:0]            sig_byte;
  logic [3:0]            sw_nib;

  // a held stage stalls the framer, so back-pressure reaches the source
  assign in_ready = !stage_valid_q || buf_in_ready;
  assign sw_nib   = sw_sig_nibble(stage_q.chan, e1_mode);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stage_valid_q <= 1'b0;
      stage_q       <= '0;
      stage_sig_q   <= 8'h00;
    end else if (in_ready) begin
      stage_valid_q <= in_valid;
      stage_q       <= in_word;
      stage_sig_q   <= tx_signaling_in;  // buffered hardware signaling
    end
  end

  assign path_raddr = in_ready ? {in_word.is_rx, in_word.chan} : {stage_q.is_rx, stage_q.chan};
  always_comb begin
    result  = stage_q;
    sig_byte = stage_q.data;
    idle_on = stage_q.is_rx ? rx_idle_enable_regs_q[stage_q.chan]
                            : tx_idle_enable_regs_q[stage_q.chan];
    if (!e1_mode && stage_q.chan >= 5'(sii_pkg::T1_CHANNELS)) begin
      idle_on = 1'b0;
    end
    if (!stage_q.is_rx) begin
      // same path whether or not the elastic store sits upstream
      if (hw_sig_mode && hw_sig_channel_select_q[stage_q.chan]) begin
        sig_byte = e1_mode ? stage_sig_q : {stage_q.data[7:1], stage_sig_q[0]};
      end else if (e1_mode && cas_mode && stage_q.chan == 5'(sii_pkg::CAS_SLOT)) begin
        // timeslot 16: upper and lower align nibbles, both from the first signaling register
        if (sig_insert_enable_q[0][sii_pkg::BIT_ALIGN_SEL]) begin
          sig_byte[7:4] = tx_sig_regs_q[0][7:4];
        end
        if (sig_insert_enable_q[2][sii_pkg::BIT_ALIGN_SEL]) begin
          sig_byte[3:0] = tx_sig_regs_q[0][3:0];
        end
      end else if (sw_sig_enable(stage_q.chan, e1_mode)) begin
        // robbed bit from nibble bit 3 in t1, nibble into the upper half of the channel byte in e1
        sig_byte = e1_mode ? {sw_nib, stage_q.data[3:0]} : {stage_q.data[7:1], sw_nib[3]};
      end
    end
    // msb of the byte leaves first, bit 0 last
    result.data = idle_on ? ram_path_rdata : sig_byte;
  end

  sii_buf2 u_buf (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_valid  (stage_valid_q),
    .in_ready  (buf_in_ready),
    .in_word   (result),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_word  (out_word)
  );

endmodule

// [sii_checker.sv]
// sii_checker: port-level assertions for sii_insert
// assumes: bound into sii_insert; one clock, async active-low reset
`timescale 1ns/100ps

module sii_checker (
  input wire logic                  sys_clk,      // clock
  input wire logic                  nrst,         // reset, active low
  input wire sii_pkg::sii_host_type host,         // register request
  input wire logic [7:0]            host_rdata_q, // read data
  input wire logic                  e1_mode,      // e1 when high
  input wire logic                  in_valid,     // byte offered
  input wire logic                  in_ready,     // byte accepted
  input wire sii_pkg::sii_word_type in_word,      // byte in
  input wire logic                  out_valid,    // byte out valid
  input wire logic                  out_ready,    // byte out taken
  input wire sii_pkg::sii_word_type out_word      // byte out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ----------
  // shadow of accepted words; the block must never reorder or drop them
  // ----------
  sii_pkg::sii_word_type fq [4];
  logic [1:0]            wp_q;
  logic [1:0]            rp_q;
  sii_pkg::sii_word_type head;
  assign head = fq[rp_q];

  always_ff @(posedge sys_clk) begin
    if (in_valid && in_ready) begin
      fq[wp_q] <= in_word;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= 2'h0;
      rp_q <= 2'h0;
    end else begin
      wp_q <= wp_q + {1'b0, in_valid && in_ready};
      rp_q <= rp_q + {1'b0, out_valid && out_ready};
    end
  end

  // ----------
  // assertions
  // ----------
  reset_idle_a: assert property ($past(nrst) == 1'b0 |-> in_ready && !out_valid)
    else $error("datapath not idle after reset");
  rdata_idle_a: assert property (!$past(host.rd) |-> host_rdata_q == 8'h00)
    else $error("read data without a read");
  enable_rw_a: assert property (host.wr && host.addr[7:2] == 6'h02 ##1
    host.rd && host.addr == $past(host.addr) |=> host_rdata_q == $past(host.wdata, 2))
    else $error("enable register readback wrong");
  addr_rw_a: assert property (host.wr && host.addr == 8'h7e ##1
    host.rd && host.addr == 8'h7e |=> host_rdata_q == $past(host.wdata, 2))
    else $error("address register readback wrong");
  ptr_step_a: assert property (host.wr && host.addr == 8'h7e ##1
    host.wr && host.addr == 8'h7f ##1 host.rd && host.addr == 8'h7e |=>
    host_rdata_q == (($past(host.wdata, 3) & 8'hc0) | (($past(host.wdata, 3) + 8'h01) & 8'h3f)))
    else $error("pointer did not advance");
  out_count_a: assert property (out_valid |-> wp_q != rp_q)
    else $error("word out without word in");
  out_slot_a: assert property (out_valid |-> out_word.chan == head.chan &&
    out_word.is_rx == head.is_rx)
    else $error("slot or direction changed");
  t1_pass_a: assert property (out_valid && !e1_mode && out_word.is_rx &&
    out_word.chan >= 5'h18 |-> out_word.data == head.data)
    else $error("t1 slot above 24 altered");
  stall_hold_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_word))
    else $error("word lost during stall");

  cover property (out_valid && !out_ready);
  cover property (in_valid && !in_ready);
  cover property (host.rd && host.addr == 8'h7f);
endmodule

bind sii_insert sii_checker u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .host(host), .host_rdata_q(host_rdata_q),
  .e1_mode(e1_mode), .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word),
  .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word)
);

// [sii_sink.sv]
// sii_sink: receiving side of the processed byte stream
// assumes: the bench pops got and drives stall and slow at clock edges
`timescale 1ns/100ps

module sii_sink (
  input  wire logic                  sys_clk,   // clock
  input  wire logic                  stall,     // refuse every word
  input  wire logic                  slow,      // take every other cycle
  input  wire logic                  out_valid, // word offered
  output logic                       out_ready, // word taken
  input  wire sii_pkg::sii_word_type out_word   // word
);
  sii_pkg::sii_word_type got [$];
  logic                  tick_q = 1'b0;

  assign out_ready = !stall && (!slow || tick_q);

  always @(posedge sys_clk) begin
    tick_q <= !tick_q;
    if (out_valid && out_ready) begin
      got.push_back(out_word);
    end
  end
endmodule

// [tb.sv]
// tb: self-checking bench for sii_insert
// assumes: sii_sink takes the output stream; host tasks keep address-then-data order
`timescale 1ns/100ps

module tb;
  // ----------
  // signals
  // ----------
  logic                  sys_clk = 1'b0;
  logic                  nrst = 1'b0;
  sii_pkg::sii_host_type host = '0;
  logic [7:0]            host_rdata_q;
  logic                  e1_mode = 1'b1;
  logic                  cas_mode = 1'b0;
  logic                  hw_sig_mode = 1'b0;
  logic                  in_valid = 1'b0;
  logic                  in_ready;
  sii_pkg::sii_word_type in_word = '0;
  logic [7:0]            tx_signaling_in = 8'h00;
  logic                  out_valid;
  logic                  out_ready;
  sii_pkg::sii_word_type out_word;
  logic                  stall = 1'b0;
  logic                  slow = 1'b0;
  int                    n_fail = 0;
  int                    n_compared = 0;
  int                    cycles = 0;
  logic [7:0]            v;
  logic [7:0]            regs [8] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h7e, 8'h80, 8'h84, 8'h88};
  localparam sii_pkg::sii_host_type N = '0;

  sii_insert dut (
    .sys_clk(sys_clk), .nrst(nrst), .host(host), .host_rdata_q(host_rdata_q),
    .e1_mode(e1_mode), .cas_mode(cas_mode), .hw_sig_mode(hw_sig_mode),
    .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word),
    .tx_signaling_in(tx_signaling_in), .out_valid(out_valid), .out_ready(out_ready),
    .out_word(out_word)
  );
  sii_sink u_sink (
    .sys_clk(sys_clk), .stall(stall), .slow(slow), .out_valid(out_valid),
    .out_ready(out_ready), .out_word(out_word)
  );

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      conclude();
    end
  end

  // ----------
  // shared tasks
  // ----------
  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic sii_pkg::sii_host_type wq(input logic [7:0] a, input logic [7:0] d);
    return {1'b1, 1'b0, a, d};
  endfunction

  function automatic sii_pkg::sii_host_type rq(input logic [7:0] a);
    return {1'b0, 1'b1, a, 8'h00};
  endfunction

  // three back-to-back request slots; rd holds what the last slot read
  task automatic bus(input sii_pkg::sii_host_type r0, r1, r2, output logic [7:0] rd);
    @(posedge sys_clk) host <= r0;
    @(posedge sys_clk) host <= r1;
    @(posedge sys_clk) host <= r2;
    @(posedge sys_clk) host <= '0;
    #1 rd = host_rdata_q;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(wq(a, d), N, N, v);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    bus(N, N, rq(a), v);
    chk("register read", v, exp);
  endtask

  task automatic send(input logic rx, input logic [4:0] ch, input logic [7:0] d, s, exp);
    int k;
    sii_pkg::sii_word_type w;
    @(posedge sys_clk);
    in_valid <= 1'b1;
    in_word <= {rx, ch, d};
    tx_signaling_in <= s;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (!in_ready && k < 50);
    in_valid <= 1'b0;
    while (u_sink.got.size() == 0 && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    w = '1;
    if (u_sink.got.size() != 0) begin
      w = u_sink.got.pop_front();
    end
    chk("channel byte", w.data, exp);
  endtask

  // ----------
  // scenarios
  // ----------
  task automatic reset_vals();
    for (int i = 0; i < 8; i++) begin
      rdc(regs[i], 8'h00);
    end
    wr(8'h00, 8'hff);
    rdc(8'h00, 8'h00);
  endtask

  task automatic reg_rw();
    for (int i = 0; i < 4; i++) begin
      bus(N, wq(8'h08 + 8'(i), 8'ha5 ^ 8'(i)), rq(8'h08 + 8'(i)), v);
      chk("enable register", v, 8'ha5 ^ 8'(i));
      wr(8'h08 + 8'(i), 8'h00);
    end
    bus(N, wq(8'h7e, 8'hc5), rq(8'h7e), v);
    chk("address register", v, 8'hc5);
  endtask

  task automatic idle_prog();
    logic [7:0] code [4] = '{8'h1e, 8'hee, 8'hff, 8'h7e};
    wr(8'h7e, 8'h02);
    bus(wq(8'h7f, code[0]), wq(8'h7f, code[1]), wq(8'h7f, code[2]), v);
    wr(8'h7f, code[3]);
    rdc(8'h7e, 8'h06);
    for (int i = 0; i < 4; i++) begin
      wr(8'h7e, 8'h02 + 8'(i));
      rdc(8'h7f, code[i]);
    end
    bus(wq(8'h7e, 8'h3f), wq(8'h7f, 8'h44), rq(8'h7e), v);
    chk("pointer wrap", v, 8'h00);
  endtask

  task automatic global_fill();
    wr(8'h7e, 8'h20);
    wr(8'h7f, 8'h11);
    wr(8'h7e, 8'h45);
    wr(8'h7f, 8'h5a);
    rdc(8'h7e, 8'h46);
    wr(8'h7e, 8'h1f);
    rdc(8'h7f, 8'h5a);
    wr(8'h7e, 8'h20);
    rdc(8'h7f, 8'h11);
    wr(8'h7e, 8'hbf);
    wr(8'h7f, 8'hc3);
    wr(8'h7e, 8'h20);
    rdc(8'h7f, 8'hc3);
    wr(8'h7e, 8'h05);
    rdc(8'h7f, 8'h5a);
    wr(8'h7e, 8'h02);
    wr(8'h7f, 8'h1e);
  endtask

  task automatic idle_path();
    wr(8'h80, 8'h04);
    wr(8'h84, 8'h02);
    wr(8'h87, 8'hff);
    send(1'b0, 5'h02, 8'h33, 8'h00, 8'h1e);
    send(1'b0, 5'h03, 8'h33, 8'h00, 8'h33);
    send(1'b1, 5'h01, 8'h44, 8'h00, 8'hc3);
    send(1'b1, 5'h02, 8'h44, 8'h00, 8'h44);
    send(1'b1, 5'h19, 8'h44, 8'h00, 8'hc3);
    e1_mode <= 1'b0;
    send(1'b1, 5'h19, 8'h44, 8'h00, 8'h44);
    e1_mode <= 1'b1;
    wr(8'h80, 8'h00);
    wr(8'h84, 8'h00);
    wr(8'h87, 8'h00);
  endtask

  task automatic sig_sw();
    cas_mode <= 1'b1;
    wr(8'h50, 8'h5b);
    wr(8'h51, 8'h9a);
    wr(8'h08, 8'h07);
    wr(8'h0a, 8'h01);
    send(1'b0, 5'h10, 8'h66, 8'h00, 8'h5b);
    send(1'b0, 5'h01, 8'h33, 8'h00, 8'ha3);
    send(1'b0, 5'h02, 8'h33, 8'h00, 8'h93);
    wr(8'h0a, 8'h00);
    send(1'b0, 5'h10, 8'h66, 8'h00, 8'h56);
    wr(8'h08, 8'h00);
    send(1'b0, 5'h10, 8'h66, 8'h00, 8'h66);
    cas_mode <= 1'b0;
    e1_mode <= 1'b0;
    wr(8'h08, 8'h01);
    wr(8'h50, 8'h08);
    send(1'b0, 5'h00, 8'h40, 8'h00, 8'h41);
    send(1'b0, 5'h01, 8'h41, 8'h00, 8'h41);
    wr(8'h08, 8'h00);
    e1_mode <= 1'b1;
  endtask

  task automatic sig_hw();
    hw_sig_mode <= 1'b1;
    slow <= 1'b1;
    wr(8'h88, 8'h08);
    send(1'b0, 5'h03, 8'h33, 8'ha5, 8'ha5);
    send(1'b0, 5'h04, 8'h33, 8'ha5, 8'h33);
    e1_mode <= 1'b0;
    send(1'b0, 5'h03, 8'h32, 8'h01, 8'h33);
    e1_mode <= 1'b1;
    hw_sig_mode <= 1'b0;
    slow <= 1'b0;
  endtask

  task automatic fill_drain();
    int took;
    sii_pkg::sii_word_type w;
    took = 0;
    @(posedge sys_clk);
    stall <= 1'b1;
    in_valid <= 1'b1;
    in_word <= {1'b1, 5'h0a, 8'h00};
    repeat (8) begin
      @(posedge sys_clk);
      if (in_ready) begin
        took++;
        in_word <= {1'b1, 5'h0a, 8'(took)};
      end
    end
    in_valid <= 1'b0;
    stall <= 1'b0;
    chk("words held", 8'(took), 8'h03);
    repeat (10) @(posedge sys_clk);
    chk("words out", 8'(u_sink.got.size()), 8'h03);
    for (int k = 0; k < 3; k++) begin
      w = u_sink.got.pop_front();
      chk("word order", w.data, 8'(k));
    end
  endtask

  task automatic mid_reset();
    for (int i = 0; i < 8; i++) begin
      wr(regs[i], 8'h3c);
    end
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    reset_vals();
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    reset_vals();
    reg_rw();
    idle_prog();
    global_fill();
    idle_path();
    sig_sw();
    sig_hw();
    fill_drain();
    mid_reset();
    conclude();
  end
endmodule
